// ===== hdl/fws_regs.svh
`ifndef FWS_REGS_SVH
`define FWS_REGS_SVH
// register byte offsets on the avalon slave
`define FWS_OFS_CTRL 5'h00
`define FWS_OFS_ADDR 5'h04
`define FWS_OFS_CMD 5'h08
`define FWS_OFS_CMDADDR 5'h0c
`define FWS_OFS_STATUS 5'h10
`define FWS_OFS_RDATA 5'h14
// control fields
`define FWS_CTRL_GO 0
`define FWS_CTRL_STOP 1
`define FWS_CTRL_PACE_CE 2
`define FWS_CTRL_SEL_SECTOR 3
`define FWS_CTRL_WIN_CHK 4
`define FWS_CMD_TAIL 16
// status fields
`define FWS_ST_BUSY 0
`define FWS_ST_DONE 1
`define FWS_ST_FAIL 2
`define FWS_ST_WINDOW 3
`define FWS_ST_OP_TOG 4
`define FWS_ST_SEC_TOG 5
`define FWS_ST_REJECT 6
`define FWS_ST_READY 7
// flash data bus status bits
`define FWS_DQ_SECTOR_TOG 2
`define FWS_DQ_WINDOW 3
`define FWS_DQ_TIMEOUT 5
`define FWS_DQ_OP_TOG 6
// reset values
`define FWS_RST_CTRL 3'h0
`define FWS_RST_ADDR 22'h000000
`define FWS_RST_DATA 16'h0000
`define FWS_CMD_RESET 16'h00f0
// timing
`define FWS_CLK_MHZ 100
`define FWS_T_PULSE_NS 70
`define FWS_PULSE_CYC ((`FWS_T_PULSE_NS * `FWS_CLK_MHZ + 999) / 1000)
`define FWS_T_GAP_NS 30
`define FWS_GAP_CYC ((`FWS_T_GAP_NS * `FWS_CLK_MHZ + 999) / 1000)
`define FWS_T_ERASE_GAP_US 50
`define FWS_ERASE_GAP_CYC (`FWS_T_ERASE_GAP_US * `FWS_CLK_MHZ)
`endif

// ===== hdl/fws_pkg.sv
package fws_pkg;
	typedef logic [21:0] fws_addr_t;
	typedef logic [15:0] fws_data_t;
	typedef enum logic [3:0] {
		FWS_IDLE,
		FWS_POLL1,
		FWS_POLL2,
		FWS_ARRAY,
		FWS_RESET,
		FWS_PRE_CHK,
		FWS_CMD,
		FWS_ACK1,
		FWS_ACK2
	} fws_state_e;
	typedef enum logic [1:0] {
		FWS_CY_IDLE,
		FWS_CY_SETUP,
		FWS_CY_PULSE,
		FWS_CY_GAP
	} fws_cyc_e;
endpackage

// ===== hdl/fws_pin_sync.sv
`timescale 1ns/10ps
module fws_pin_sync
#(
	parameter int W = 17
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] s1_r, s2_r, s3_r, q_r, q_nxt;

	// s1 feeds only s2; a bit moves once the later two stages agree
	for (genvar i = 0; i < W; i++)
	begin : g_bit
		assign q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_r[i];
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s1_r <= '1;
			s2_r <= '1;
			s3_r <= '1;
			q_r <= '1;
		end
		else
		begin
			s1_r <= pin_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q_r <= q_nxt;
		end
	end

	assign q_o = q_r;
endmodule

// ===== hdl/fws_flash_cycle.sv
`timescale 1ns/10ps
`include "fws_regs.svh"
module fws_flash_cycle
	import fws_pkg::*;
#(
	parameter int PULSE_CYC = `FWS_PULSE_CYC,
	parameter int GAP_CYC = `FWS_GAP_CYC,
	parameter int SYNC_CYC = 3
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic write_i,
	input wire logic pace_ce_i,
	input wire fws_addr_t addr_i,
	input wire fws_data_t data_i,
	input wire fws_data_t dq_sync_i,
	output logic done_o,
	output fws_data_t rdata_o,
	output fws_addr_t addr_o,
	output fws_data_t dq_o,
	output logic dq_oe_o,
	output logic ce_n_o,
	output logic oe_n_o,
	output logic we_n_o
);
	// reads hold the strobe through the synchroniser latency
	localparam int RD_CYC = PULSE_CYC + SYNC_CYC;
	fws_cyc_e ph_r, ph_nxt;
	logic [7:0] cnt_r, cnt_nxt;
	logic wr_r, wr_nxt, pace_r, pace_nxt, done_r, done_nxt;
	logic oe_r, oe_nxt, ce_n_r, ce_n_nxt, oe_n_r, oe_n_nxt;
	logic we_n_r, we_n_nxt;
	fws_addr_t addr_r, addr_nxt;
	fws_data_t dq_r, dq_nxt, rd_r, rd_nxt;

	always_comb
	begin
		ph_nxt = ph_r;
		cnt_nxt = cnt_r;
		wr_nxt = wr_r;
		pace_nxt = pace_r;
		done_nxt = 1'b0;
		oe_nxt = oe_r;
		ce_n_nxt = ce_n_r;
		oe_n_nxt = oe_n_r;
		we_n_nxt = we_n_r;
		addr_nxt = addr_r;
		dq_nxt = dq_r;
		rd_nxt = rd_r;
		unique case (ph_r)
			FWS_CY_IDLE:
				if (start_i)
				begin
					ph_nxt = FWS_CY_SETUP;
					addr_nxt = addr_i;
					dq_nxt = data_i;
					wr_nxt = write_i;
					pace_nxt = pace_ce_i && !write_i;
					oe_nxt = write_i;
					// the strobe that does not pace is held low
					if (pace_ce_i && !write_i)
						oe_n_nxt = 1'b0;
					else
						ce_n_nxt = 1'b0;
				end
			FWS_CY_SETUP:
			begin
				ph_nxt = FWS_CY_PULSE;
				cnt_nxt = wr_r ? 8'(PULSE_CYC - 1) : 8'(RD_CYC - 1);
				if (wr_r)
					we_n_nxt = 1'b0;
				else if (pace_r)
					ce_n_nxt = 1'b0;
				else
					oe_n_nxt = 1'b0;
			end
			FWS_CY_PULSE:
				if (cnt_r == 8'h00)
				begin
					ph_nxt = FWS_CY_GAP;
					cnt_nxt = 8'(GAP_CYC - 1);
					we_n_nxt = 1'b1;
					if (!wr_r)
						rd_nxt = dq_sync_i;
					if (pace_r)
						ce_n_nxt = 1'b1;
					else if (!wr_r)
						oe_n_nxt = 1'b1;
				end
				else
					cnt_nxt = cnt_r - 8'h01;
			FWS_CY_GAP:
				if (cnt_r == 8'h00)
				begin
					ph_nxt = FWS_CY_IDLE;
					ce_n_nxt = 1'b1;
					oe_n_nxt = 1'b1;
					oe_nxt = 1'b0;
					done_nxt = 1'b1;
				end
				else
					cnt_nxt = cnt_r - 8'h01;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ph_r <= FWS_CY_IDLE;
			cnt_r <= 8'h00;
			wr_r <= 1'b0;
			pace_r <= 1'b0;
			done_r <= 1'b0;
			oe_r <= 1'b0;
			ce_n_r <= 1'b1;
			oe_n_r <= 1'b1;
			we_n_r <= 1'b1;
			addr_r <= `FWS_RST_ADDR;
			dq_r <= `FWS_RST_DATA;
			rd_r <= `FWS_RST_DATA;
		end
		else
		begin
			ph_r <= ph_nxt;
			cnt_r <= cnt_nxt;
			wr_r <= wr_nxt;
			pace_r <= pace_nxt;
			done_r <= done_nxt;
			oe_r <= oe_nxt;
			ce_n_r <= ce_n_nxt;
			oe_n_r <= oe_n_nxt;
			we_n_r <= we_n_nxt;
			addr_r <= addr_nxt;
			dq_r <= dq_nxt;
			rd_r <= rd_nxt;
		end
	end

	assign done_o = done_r;
	assign rdata_o = rd_r;
	assign addr_o = addr_r;
	assign dq_o = dq_r;
	assign dq_oe_o = oe_r;
	assign ce_n_o = ce_n_r;
	assign oe_n_o = oe_n_r;
	assign we_n_o = we_n_r;

	AST_READ_PACE: assert property (@(posedge clk_i) disable iff (rst_i)
		(ph_r == FWS_CY_GAP && !wr_r) |-> (pace_r ? (ce_n_r && !oe_n_r)
		: (oe_n_r && !ce_n_r)))
		else $error("read pacing strobe not released");
	AST_NO_WE_OE: assert property (@(posedge clk_i) disable iff (rst_i)
		!(!we_n_r && !oe_n_r))
		else $error("write and output strobes low together");
endmodule

// ===== hdl/fws_status_poller.sv
// Contract
// - reads paced by output or chip enable
// - host starts polling with two back-to-back reads
// - steady toggle means done; next read array
// - toggling with timeout set: retest, then reset
// - polling restarts from double read after pause
// - after timeout failure host writes reset command
// - gaps under fifty microseconds skip window checks; here only the check before the command is skipped
// - confirm acceptance, check window before and after
// - status reads use program or erase address
// - status reads address the busy bank
// - host combines both toggle bits for state; here sel_sec_r picks one of the two
`timescale 1ns/10ps
`include "fws_regs.svh"
module fws_status_poller
	import fws_pkg::*;
#(
	parameter int ERASE_GAP_CYC = `FWS_ERASE_GAP_CYC,
	parameter int PULSE_CYC = `FWS_PULSE_CYC,
	parameter int GAP_CYC = `FWS_GAP_CYC
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output fws_addr_t flash_addr_o,
	input wire fws_data_t flash_dq_i,
	output fws_data_t flash_dq_o,
	output logic flash_dq_oe_o,
	output logic flash_ce_n_o,
	output logic flash_oe_n_o,
	output logic flash_we_n_o,
	input wire logic flash_ready_busy_n_i
);
	localparam int GW = $clog2(ERASE_GAP_CYC + 1);

	////////////////////////////////////////////////////////////////////
	// pins and bus cycle engine

	logic [16:0] pins_q;
	fws_data_t dq_sync, cyc_rdata;
	logic ready_sync, cyc_done;
	logic cyc_start_r, cyc_start_nxt, cyc_wr_r, cyc_wr_nxt;
	fws_addr_t cyc_addr_r, cyc_addr_nxt;
	fws_data_t cyc_data_r, cyc_data_nxt;
	logic pace_ce_r, pace_ce_nxt;

	fws_pin_sync #(.W(17)) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i({flash_ready_busy_n_i, flash_dq_i}),
		.q_o(pins_q)
	);
	assign dq_sync = pins_q[15:0];
	assign ready_sync = pins_q[16];

	fws_flash_cycle #(
		.PULSE_CYC(PULSE_CYC),
		.GAP_CYC(GAP_CYC),
		.SYNC_CYC(3)
	) u_cycle (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(cyc_start_r),
		.write_i(cyc_wr_r),
		.pace_ce_i(pace_ce_r),
		.addr_i(cyc_addr_r),
		.data_i(cyc_data_r),
		.dq_sync_i(dq_sync),
		.done_o(cyc_done),
		.rdata_o(cyc_rdata),
		.addr_o(flash_addr_o),
		.dq_o(flash_dq_o),
		.dq_oe_o(flash_dq_oe_o),
		.ce_n_o(flash_ce_n_o),
		.oe_n_o(flash_oe_n_o),
		.we_n_o(flash_we_n_o)
	);

	////////////////////////////////////////////////////////////////////
	// avalon slave and software registers

	fws_state_e state_r, state_nxt;
	logic waitreq_r, waitreq_nxt;
	logic [31:0] rdata_bus_r, rdata_bus_nxt, wm, st;
	logic sel_sec_r, sel_sec_nxt, win_chk_r, win_chk_nxt;
	logic stop_r, stop_nxt, tail_r, tail_nxt, stop_take;
	fws_addr_t poll_addr_r, poll_addr_nxt, cmd_addr_r, cmd_addr_nxt;
	fws_data_t cmd_data_r, cmd_data_nxt, last_rd_r;
	logic done_ok_r, fail_r, reject_r, window_r, op_tog_r, sec_tog_r;
	logic busy, launch, acc, go, cmd_go, wr_ctrl;

	always_comb
	begin
		wm = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
			{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
		busy = state_r != FWS_IDLE;
		wr_ctrl = avs_write_i && avs_address_i == `FWS_OFS_CTRL &&
			avs_byteenable_i[0];
		// a new operation while one runs is stalled, not dropped
		launch = (wr_ctrl && avs_writedata_i[`FWS_CTRL_GO]) ||
			(avs_write_i && avs_address_i == `FWS_OFS_CMD);
		acc = (avs_read_i || avs_write_i) && !waitreq_r;
		waitreq_nxt = !((avs_read_i || avs_write_i) && waitreq_r &&
			!(busy && launch));
		go = acc && wr_ctrl && avs_writedata_i[`FWS_CTRL_GO];
		cmd_go = acc && avs_write_i && avs_address_i == `FWS_OFS_CMD;
		pace_ce_nxt = pace_ce_r;
		sel_sec_nxt = sel_sec_r;
		win_chk_nxt = win_chk_r;
		if (acc && wr_ctrl)
		begin
			pace_ce_nxt = avs_writedata_i[`FWS_CTRL_PACE_CE];
			sel_sec_nxt = avs_writedata_i[`FWS_CTRL_SEL_SECTOR];
			win_chk_nxt = avs_writedata_i[`FWS_CTRL_WIN_CHK];
		end
		// a stop request that lands as the poller takes one is kept
		stop_nxt = (stop_r && !stop_take && !go) ||
			(acc && wr_ctrl && avs_writedata_i[`FWS_CTRL_STOP]);
		poll_addr_nxt = poll_addr_r;
		if (acc && avs_write_i && avs_address_i == `FWS_OFS_ADDR)
			poll_addr_nxt = (poll_addr_r & ~wm[21:0]) |
				(avs_writedata_i[21:0] & wm[21:0]);
		cmd_addr_nxt = cmd_addr_r;
		if (acc && avs_write_i && avs_address_i == `FWS_OFS_CMDADDR)
			cmd_addr_nxt = (cmd_addr_r & ~wm[21:0]) |
				(avs_writedata_i[21:0] & wm[21:0]);
		cmd_data_nxt = cmd_data_r;
		tail_nxt = tail_r;
		if (cmd_go)
		begin
			cmd_data_nxt = (cmd_data_r & ~wm[15:0]) |
				(avs_writedata_i[15:0] & wm[15:0]);
			tail_nxt = avs_writedata_i[`FWS_CMD_TAIL] && wm[16];
		end
		st = 32'h00000000;
		st[`FWS_ST_BUSY] = busy;
		st[`FWS_ST_DONE] = done_ok_r;
		st[`FWS_ST_FAIL] = fail_r;
		st[`FWS_ST_WINDOW] = window_r;
		st[`FWS_ST_OP_TOG] = op_tog_r;
		st[`FWS_ST_SEC_TOG] = sec_tog_r;
		st[`FWS_ST_REJECT] = reject_r;
		st[`FWS_ST_READY] = ready_sync;
		rdata_bus_nxt = rdata_bus_r;
		if (avs_read_i && waitreq_r)
		begin
			unique case (avs_address_i)
				`FWS_OFS_CTRL: rdata_bus_nxt = {27'h0000000, win_chk_r,
					sel_sec_r, pace_ce_r, stop_r, 1'b0};
				`FWS_OFS_ADDR: rdata_bus_nxt = {10'h000, poll_addr_r};
				`FWS_OFS_CMD: rdata_bus_nxt = {15'h0000, tail_r, cmd_data_r};
				`FWS_OFS_CMDADDR: rdata_bus_nxt = {10'h000, cmd_addr_r};
				`FWS_OFS_STATUS: rdata_bus_nxt = st;
				`FWS_OFS_RDATA: rdata_bus_nxt = {16'h0000, last_rd_r};
				default: rdata_bus_nxt = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			waitreq_r <= 1'b1;
			rdata_bus_r <= 32'h00000000;
			pace_ce_r <= 1'b0;
			sel_sec_r <= 1'b0;
			win_chk_r <= 1'b0;
			stop_r <= 1'b0;
			poll_addr_r <= `FWS_RST_ADDR;
			cmd_addr_r <= `FWS_RST_ADDR;
			cmd_data_r <= `FWS_RST_DATA;
			tail_r <= 1'b0;
		end
		else
		begin
			waitreq_r <= waitreq_nxt;
			rdata_bus_r <= rdata_bus_nxt;
			pace_ce_r <= pace_ce_nxt;
			sel_sec_r <= sel_sec_nxt;
			win_chk_r <= win_chk_nxt;
			stop_r <= stop_nxt;
			poll_addr_r <= poll_addr_nxt;
			cmd_addr_r <= cmd_addr_nxt;
			cmd_data_r <= cmd_data_nxt;
			tail_r <= tail_nxt;
		end
	end

	assign avs_readdata_o = rdata_bus_r;
	assign avs_waitrequest_o = waitreq_r;

	////////////////////////////////////////////////////////////////////
	// toggle polling and command sequencer

	fws_data_t prev_r, prev_nxt, last_rd_nxt;
	logic rechk_r, rechk_nxt, again, tog, tog_op, tog_sec;
	logic done_ok_nxt, fail_nxt, reject_nxt, window_nxt;
	logic op_tog_nxt, sec_tog_nxt;
	logic [GW-1:0] gap_cnt_r, gap_cnt_nxt;

	always_comb
	begin
		state_nxt = state_r;
		prev_nxt = prev_r;
		rechk_nxt = rechk_r;
		done_ok_nxt = done_ok_r;
		fail_nxt = fail_r;
		reject_nxt = reject_r;
		window_nxt = window_r;
		op_tog_nxt = op_tog_r;
		sec_tog_nxt = sec_tog_r;
		last_rd_nxt = cyc_done ? cyc_rdata : last_rd_r;
		stop_take = 1'b0;
		again = 1'b0;
		gap_cnt_nxt = (gap_cnt_r == GW'(ERASE_GAP_CYC)) ? gap_cnt_r :
			gap_cnt_r + GW'(1);
		tog_op = cyc_rdata[`FWS_DQ_OP_TOG] ^ prev_r[`FWS_DQ_OP_TOG];
		tog_sec = cyc_rdata[`FWS_DQ_SECTOR_TOG] ^
			prev_r[`FWS_DQ_SECTOR_TOG];
		tog = sel_sec_r ? tog_sec : tog_op;
		unique case (state_r)
			FWS_IDLE:
				if (go)
				begin
					state_nxt = FWS_POLL1;
					rechk_nxt = 1'b0;
					done_ok_nxt = 1'b0;
					fail_nxt = 1'b0;
				end
				else if (cmd_go)
				begin
					reject_nxt = 1'b0;
					// back-to-back sector erases skip the window read before the command
					if (tail_nxt && win_chk_r &&
						gap_cnt_r == GW'(ERASE_GAP_CYC))
						state_nxt = FWS_PRE_CHK;
					else
						state_nxt = FWS_CMD;
				end
			FWS_POLL1:
				if (cyc_done)
				begin
					prev_nxt = cyc_rdata;
					window_nxt = cyc_rdata[`FWS_DQ_WINDOW];
					state_nxt = FWS_POLL2;
				end
			FWS_POLL2:
				if (cyc_done)
				begin
					window_nxt = cyc_rdata[`FWS_DQ_WINDOW];
					op_tog_nxt = tog_op;
					sec_tog_nxt = tog_sec;
					prev_nxt = cyc_rdata;
					if (!tog)
						state_nxt = FWS_ARRAY;
					else if (rechk_r)
						state_nxt = FWS_RESET;
					else if (cyc_rdata[`FWS_DQ_TIMEOUT])
					begin
						rechk_nxt = 1'b1;
						again = 1'b1;
					end
					else if (stop_r)
					begin
						stop_take = 1'b1;
						state_nxt = FWS_IDLE;
					end
					else
						again = 1'b1;
				end
			FWS_ARRAY:
				if (cyc_done)
				begin
					done_ok_nxt = 1'b1;
					state_nxt = FWS_IDLE;
				end
			FWS_RESET:
				if (cyc_done)
				begin
					fail_nxt = 1'b1;
					state_nxt = FWS_IDLE;
				end
			FWS_PRE_CHK:
				if (cyc_done)
				begin
					window_nxt = cyc_rdata[`FWS_DQ_WINDOW];
					// erase already running: the command would be ignored
					if (cyc_rdata[`FWS_DQ_WINDOW])
					begin
						reject_nxt = 1'b1;
						state_nxt = FWS_IDLE;
					end
					else
						state_nxt = FWS_CMD;
				end
			FWS_CMD:
				if (cyc_done)
				begin
					if (tail_r)
						gap_cnt_nxt = '0;
					if (tail_r && win_chk_r)
						state_nxt = FWS_ACK1;
					else
						state_nxt = FWS_IDLE;
				end
			FWS_ACK1:
				if (cyc_done)
				begin
					prev_nxt = cyc_rdata;
					state_nxt = FWS_ACK2;
				end
			FWS_ACK2:
				if (cyc_done)
				begin
					window_nxt = cyc_rdata[`FWS_DQ_WINDOW];
					if (!tog_op || cyc_rdata[`FWS_DQ_WINDOW])
						reject_nxt = 1'b1;
					state_nxt = FWS_IDLE;
				end
		endcase
		cyc_start_nxt = again ||
			(state_nxt != state_r && state_nxt != FWS_IDLE);
		cyc_wr_nxt = state_nxt == FWS_CMD || state_nxt == FWS_RESET;
		// polling reads go to the polled address; window checks and the command use the command address
		unique case (state_nxt)
			FWS_PRE_CHK, FWS_CMD, FWS_ACK1, FWS_ACK2:
				cyc_addr_nxt = cmd_addr_r;
			default:
				cyc_addr_nxt = poll_addr_r;
		endcase
		cyc_data_nxt = (state_nxt == FWS_RESET) ? `FWS_CMD_RESET :
			cmd_data_r;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_r <= FWS_IDLE;
			prev_r <= `FWS_RST_DATA;
			last_rd_r <= `FWS_RST_DATA;
			rechk_r <= 1'b0;
			done_ok_r <= 1'b0;
			fail_r <= 1'b0;
			reject_r <= 1'b0;
			window_r <= 1'b0;
			op_tog_r <= 1'b0;
			sec_tog_r <= 1'b0;
			gap_cnt_r <= GW'(ERASE_GAP_CYC);
			cyc_start_r <= 1'b0;
			cyc_wr_r <= 1'b0;
			cyc_addr_r <= `FWS_RST_ADDR;
			cyc_data_r <= `FWS_RST_DATA;
		end
		else
		begin
			state_r <= state_nxt;
			prev_r <= prev_nxt;
			last_rd_r <= last_rd_nxt;
			rechk_r <= rechk_nxt;
			done_ok_r <= done_ok_nxt;
			fail_r <= fail_nxt;
			reject_r <= reject_nxt;
			window_r <= window_nxt;
			op_tog_r <= op_tog_nxt;
			sec_tog_r <= sec_tog_nxt;
			gap_cnt_r <= gap_cnt_nxt;
			cyc_start_r <= cyc_start_nxt;
			cyc_wr_r <= cyc_wr_nxt;
			cyc_addr_r <= cyc_addr_nxt;
			cyc_data_r <= cyc_data_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks

	AST_TWO_READS: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(state_r == FWS_POLL2) |-> $past(state_r) == FWS_POLL1)
		else $error("compare reached without a first read");
	AST_STEADY_ARRAY: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_r == FWS_POLL2 && cyc_done && !tog) |=>
		(state_r == FWS_ARRAY && cyc_start_r && !cyc_wr_r)
		##[1:60] (done_ok_r && state_r == FWS_IDLE))
		else $error("steady toggle not followed by array read");
	AST_TIMEOUT_RETEST: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_r == FWS_POLL2 && cyc_done && tog && !rechk_r &&
		cyc_rdata[`FWS_DQ_TIMEOUT]) |=>
		(state_r == FWS_POLL2 && rechk_r && cyc_start_r))
		else $error("timeout bit did not trigger a retest");
	AST_RETEST_FAIL: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_r == FWS_POLL2 && cyc_done && tog && rechk_r) |=>
		state_r == FWS_RESET)
		else $error("still toggling after retest but no reset");
	AST_RESET_CMD: assert property (@(posedge clk_i) disable iff (rst_i)
		(cyc_start_r && state_r == FWS_RESET) |->
		(cyc_wr_r && cyc_data_r == `FWS_CMD_RESET))
		else $error("reset command word wrong");
	AST_FAIL_FLAG: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_r == FWS_RESET && cyc_done) |=> (fail_r && !busy))
		else $error("fail flag not set after reset command");
	AST_RESTART: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_r == FWS_IDLE && go) |=>
		(state_r == FWS_POLL1 && !rechk_r && cyc_start_r))
		else $error("polling did not restart at the first read");
	AST_STATUS_ADDR: assert property (@(posedge clk_i) disable iff (rst_i)
		(cyc_start_r && (state_r == FWS_POLL1 || state_r == FWS_POLL2))
		|-> (!cyc_wr_r && cyc_addr_r == poll_addr_r))
		else $error("status read not at the polled address");
	AST_POST_REJECT: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_r == FWS_ACK2 && cyc_done && cyc_rdata[`FWS_DQ_WINDOW])
		|=> (reject_r && state_r == FWS_IDLE))
		else $error("closed window after command not reported");
	AST_GAP_SKIP: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_r == FWS_IDLE && cmd_go && !go &&
		gap_cnt_r != GW'(ERASE_GAP_CYC)) |=> state_r == FWS_CMD)
		else $error("window check not skipped inside the gap");
	AST_WAIT_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
		!waitreq_r |=> waitreq_r)
		else $error("waitrequest low for more than one cycle");
endmodule

// ===== verification/fws_flash_model.sv
`timescale 1ns/10ps
module fws_flash_model
	import fws_pkg::*;
(
	input wire fws_addr_t addr_i,
	input wire fws_data_t dq_i,
	input wire logic ce_n_i,
	input wire logic oe_n_i,
	input wire logic we_n_i,
	output fws_data_t dq_o,
	output logic ready_busy_n_o
);
	localparam fws_data_t ARRAY = 16'h3c52;
	int rem = 0;
	int cmd_cnt = 0;
	logic tog = 1'b0;
	logic tout = 1'b0;
	logic win = 1'b0;
	fws_data_t last = 16'h0000;
	fws_data_t last_cmd = 16'h0000;
	fws_data_t cur;
	// only bank 0 runs the embedded algorithm; other banks give array data
	assign cur = (rem > 0 && !addr_i[21]) ?
		{9'h000, tog, tout, 1'b0, win, tog, 2'h0} : ARRAY;
	// released bus shows the inverse of the last value, never a stale copy
	assign dq_o = (!ce_n_i && !oe_n_i) ? cur : ~last;
	assign ready_busy_n_o = (rem == 0);
	task automatic start(input int n, input logic t, input logic w);
		rem = n;
		tout = t;
		win = w;
	endtask
	// a read ends when either strobe rises
	always @(posedge (ce_n_i | oe_n_i))
	begin
		last = cur;
		if (rem > 0 && !addr_i[21])
		begin
			tog = ~tog;
			if (!tout)
				rem = rem - 1;
		end
	end
	always @(posedge (ce_n_i | we_n_i))
	begin
		if ($time > 0 && !(rem > 0 && win))
		begin
			last_cmd = dq_i;
			cmd_cnt = cmd_cnt + 1;
			rem = (dq_i == 16'h00f0) ? 0 : 6;
			tout = 1'b0;
		end
	end
endmodule

// ===== verification/fws_status_poller_tb_top.sv
`timescale 1ns/10ps
`include "fws_regs.svh"
module fws_status_poller_tb_top
	import fws_pkg::*;
;
	logic clk_i, rst_i, avs_read, avs_write, avs_waitrequest;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, st, seed;
	logic [3:0] avs_byteenable;
	fws_addr_t flash_addr;
	fws_data_t ctl_dq, mdl_dq, dq_wire;
	logic ctl_dq_oe, ce_n, oe_n, we_n, rb_n;
	int failures = 0;
	int checked = 0;
	int n0;
	assign dq_wire = ctl_dq_oe ? ctl_dq : mdl_dq;
	fws_status_poller #(.ERASE_GAP_CYC(40)) i_fws_status_poller (
		.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address),
		.avs_read_i(avs_read), .avs_write_i(avs_write),
		.avs_writedata_i(avs_writedata), .avs_byteenable_i(avs_byteenable),
		.avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest),
		.flash_addr_o(flash_addr), .flash_dq_i(dq_wire), .flash_dq_o(ctl_dq),
		.flash_dq_oe_o(ctl_dq_oe), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n),
		.flash_we_n_o(we_n), .flash_ready_busy_n_i(rb_n));
	fws_flash_model i_fws_flash_model (.addr_i(flash_addr), .dq_i(ctl_dq),
		.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .dq_o(mdl_dq),
		.ready_busy_n_o(rb_n));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] exp_st(input logic rdy, rej, fail, done);
		return {24'h0, rdy, rej, 3'h0, fail, done, 1'b0};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic av(input logic wr, input logic [4:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk_i);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		do
			@(posedge clk_i);
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] x;
		av(1'b1, a, d, x);
	endtask
	// the first status read may still precede the sequencer start
	task automatic wait_idle();
		int i;
		for (i = 0; i < 2000; i++)
		begin
			av(1'b0, `FWS_OFS_STATUS, 32'h0, st);
			if (st[0] === 1'b0 && i > 0)
				break;
		end
		if (i == 2000)
			failures++;
	endtask
	task automatic go(input fws_addr_t a, input logic [31:0] ctrl);
		wr(`FWS_OFS_ADDR, 32'(a));
		wr(`FWS_OFS_CTRL, ctrl);
		wait_idle();
	endtask
	task automatic final_report();
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk_i = 1'b0;
		forever
			#5 clk_i = ~clk_i;
	end
	initial
	begin
		// the whole run needs well under ten thousand cycles
		#500000;
		failures++;
		final_report();
	end
	initial
	begin
		rst_i = 1'b1;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		seed = $urandom(42);
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk({ce_n, oe_n, we_n, ctl_dq_oe}, 4'he);
		av(1'b0, `FWS_OFS_CTRL, 32'h0, st);
		chk(st, 32'h0);
		av(1'b0, 5'h18, 32'h0, st);
		chk(st, 32'h0);
		// both pacing modes and both toggle bits, random toggle length
		for (int i = 0; i < 4; i++)
		begin
			i_fws_flash_model.start($urandom_range(5, 0), 1'b0, 1'b0);
			go(22'($urandom) & 22'h1fffff, 32'(i) << 2 | 32'h1);
			chk(st & 32'hc7, exp_st(1, 0, 0, 1));
			chk(32'(st[4 + (i >> 1)]), 32'h0);
			av(1'b0, `FWS_OFS_RDATA, 32'h0, st);
			chk(st, 32'h3c52);
		end
		// idle bank answers with array data while bank 0 is busy
		i_fws_flash_model.start(100, 1'b0, 1'b0);
		go(22'h200000, 32'h1);
		chk(st & 32'hc7, exp_st(0, 0, 0, 1));
		i_fws_flash_model.start(50, 1'b1, 1'b0);
		go(22'h000100, 32'h1);
		chk(st & 32'hc7, exp_st(1, 0, 1, 0));
		chk(32'(i_fws_flash_model.last_cmd), 32'h00f0);
		// stop in mid-poll, then a fresh start must begin again
		i_fws_flash_model.start(300, 1'b0, 1'b0);
		wr(`FWS_OFS_CTRL, 32'h1);
		repeat (200) @(posedge clk_i);
		wr(`FWS_OFS_CTRL, 32'h2);
		wait_idle();
		chk(st & 32'hc7, exp_st(0, 0, 0, 0));
		i_fws_flash_model.start(1, 1'b0, 1'b0);
		// a second go while polling is stalled until the poll ends
		wr(`FWS_OFS_CTRL, 32'h1);
		go(22'h000100, 32'h1);
		chk(st & 32'hc7, exp_st(1, 0, 0, 1));
		// sector erase tail with window checks
		i_fws_flash_model.start(0, 1'b0, 1'b0);
		wr(`FWS_OFS_CTRL, 32'h10);
		av(1'b0, `FWS_OFS_CTRL, 32'h0, st);
		chk(st, 32'h10);
		wr(`FWS_OFS_CMDADDR, 32'($urandom) & 32'h1fffff);
		n0 = i_fws_flash_model.cmd_cnt;
		wr(`FWS_OFS_CMD, 32'h0001_0030);
		wait_idle();
		chk(32'(st[6]), 32'h0);
		chk(32'(i_fws_flash_model.cmd_cnt), 32'(n0 + 1));
		chk(32'(i_fws_flash_model.last_cmd), 32'h0030);
		// window now closed: command must be held back and flagged
		i_fws_flash_model.start(6, 1'b0, 1'b1);
		repeat (60) @(posedge clk_i);
		wr(`FWS_OFS_CMD, 32'h0001_0030);
		wait_idle();
		chk(32'(st[6]), 32'h1);
		chk(32'(st[3]), 32'h1);
		chk(32'(i_fws_flash_model.cmd_cnt), 32'(n0 + 1));
		// a tail command soon after the last one skips the pre-check
		i_fws_flash_model.start(0, 1'b0, 1'b0);
		wr(`FWS_OFS_CTRL, 32'h0);
		wr(`FWS_OFS_CMD, 32'h0001_0030);
		wait_idle();
		wr(`FWS_OFS_CTRL, 32'h10);
		wr(`FWS_OFS_CMD, 32'h0001_0030);
		wait_idle();
		chk(32'(st[6]), 32'h0);
		chk(32'(i_fws_flash_model.cmd_cnt), 32'(n0 + 3));
		final_report();
	end
endmodule
